/* File: core/shared_period_pwm_channels.sv */
// Four PWM channels sharing one 8-bit period timer and prescaler, on an AXI4-Lite slave.
// Assumes a 200 MHz mclk, synchronous inputs, and an external pad that honours pin_oe.
// Notes on behaviour
// - Output goes active at timer restart, inactive when time base equals buffered duty.
// - Duty registers are double buffered, loaded into compare buffers at period match.
// - After timer equals period: timer clears, output activates, buffers load; zero stays low.
// - Ten-bit time base is timer value extended by two prescaled clock bits.
// - Resolution is log2 of four times period plus one, ten bits maximum.
// - Pulse width above period leaves the pin unchanged, no falling edge.
// - Prescaler divides by one, four or sixty-four.
// - During sleep the timer does not count and no channel state changes.
// - During sleep a driven pin keeps its level.
// - After sleep the timer continues from its held value.
// - Output frequency follows the system clock proportionally.
// - Any reset returns registers other than duty to reset values and releases the pins.
// - Control bit seven enables the channel.
// - Control bit six routes the waveform to the pin while bit seven is set, else releases it.
// - Control bit five is read-only and shows the channel output value.
// - Control bit four selects active-low output when set.
// - Duty high register holds the eight upper duty bits.
// - Duty low register holds two lower bits in seven:six, rest read zero.
// - Unimplemented channel register bits read zero and ignore writes.
// - Control clears on every reset; duty registers keep contents across resets.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_regs.svh"
module shared_period_pwm_channels
  import pwm_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic sleep,
  input wire axil_req_s axil_req,
  output axil_rsp_s axil_rsp,
  output logic [`CH_NUM-1:0] pwm_out,
  output logic [`CH_NUM-1:0] pin_out,
  output logic [`CH_NUM-1:0] pin_oe
);
  state_s state_reg;
  state_s state_next;
  // Duty registers sit outside the reset record so that they survive resets.
  logic [`CH_NUM-1:0][9:0] duty_reg;
  logic [`CH_NUM-1:0][9:0] duty_next;
  logic [`CH_NUM-1:0] pin_out_reg;
  logic run;
  logic tick;
  logic period_hit;
  logic restart;
  logic [9:0] tb_next;
  logic wr_go;
  logic [7:0] wa;
  logic [7:0] ra;
  logic [7:0] wb;

  assign run = clk_en && !sleep;
  assign wa = axil_req.awaddr;
  assign ra = axil_req.araddr;
  assign wb = axil_req.wdata[7:0];
  // Requests are taken only while the block runs, so a frozen block never swallows a
  // handshake that its state cannot record.
  assign wr_go = run && axil_req.awvalid && axil_req.wvalid && (state_reg.wst == BUS_IDLE);

  // The prescaler is one free-running count; the timer steps when the bits of the chosen
  // ratio and the two sub-step bits above them have all wrapped.
  always_comb
  begin
    case (state_reg.prescale)
      `PRESCALE_1: tick = (state_reg.pre_cnt[1:0] == `DIV1_TOP);
      `PRESCALE_4: tick = (state_reg.pre_cnt[3:0] == `DIV4_TOP);
      default: tick = (state_reg.pre_cnt == `DIV64_TOP);
    endcase
  end

  assign period_hit = (state_reg.timer == state_reg.period);
  // The full period spans four sub-steps per timer count, giving 4*(period+1) steps.
  assign restart = state_reg.timer_run && tick && period_hit;

  always_comb
  begin
    state_next = state_reg;
    duty_next = duty_reg;
    axil_rsp = '0;
    axil_rsp.awready = wr_go;
    axil_rsp.wready = wr_go;
    axil_rsp.arready = run && (state_reg.rst == BUS_IDLE);
    axil_rsp.bvalid = (state_reg.wst == BUS_BRESP);
    axil_rsp.bresp = state_reg.bresp;
    axil_rsp.rvalid = (state_reg.rst == BUS_RRESP);
    axil_rsp.rdata = state_reg.rdata;
    axil_rsp.rresp = state_reg.rresp;
    if (state_reg.timer_run)
    begin
      state_next.pre_cnt = state_reg.pre_cnt + 8'h01;
      if (restart)
      begin
        state_next.timer = 8'h00;
        state_next.match_flag = 1'b1;
      end
      else if (tick)
        state_next.timer = state_reg.timer + 8'h01;
    end
    // The compare looks at the time base of the coming cycle, so the output falls exactly
    // when the time base reaches the duty value and not one clock later.
    // The two low bits count prescaled clocks; at 1:1 they count mclk itself.
    case (state_reg.prescale)
      `PRESCALE_1: tb_next = {state_next.timer, state_next.pre_cnt[1:0]};
      `PRESCALE_4: tb_next = {state_next.timer, state_next.pre_cnt[3:2]};
      default: tb_next = {state_next.timer, state_next.pre_cnt[7:6]};
    endcase
    for (int i = 0; i < `CH_NUM; i++)
    begin
      if (restart)
      begin
        state_next.ch[i].duty_buf = duty_reg[i];
        state_next.ch[i].raw = (duty_reg[i] != 10'h000);
      end
      // A duty value at or beyond four times the period never matches: full duty.
      else if (tb_next == state_reg.ch[i].duty_buf
        && state_reg.ch[i].duty_buf < {state_reg.period, 2'h0})
        state_next.ch[i].raw = 1'b0;
      // A disabled channel parks its waveform low so that enabling it starts clean.
      if (!state_reg.ch[i].en)
        state_next.ch[i].raw = 1'b0;
    end
    case (state_reg.wst)
      BUS_IDLE:
      begin
        if (wr_go)
        begin
          state_next.wst = BUS_BRESP;
          state_next.bresp = 2'h0;
          if (!axil_req.wstrb[0])
            state_next.bresp = 2'h0;
          else if (wa == `OFF_TIMER_CTRL)
          begin
            state_next.timer_run = wb[`TCTRL_RUN_BIT];
            state_next.prescale = wb[1:0];
          end
          else if (wa == `OFF_PERIOD)
            state_next.period = wb;
          else if (wa == `OFF_TIMER)
            state_next.timer = wb;
          // A match in the same cycle as the clear wins, so no period boundary is lost.
          else if (wa == `OFF_STATUS)
            state_next.match_flag = state_next.match_flag & ~wb[0] | restart;
          else if (wa >= `OFF_CH_BASE && wa < `OFF_CH_BASE + `CH_NUM * `CH_STRIDE)
          begin
            for (int i = 0; i < `CH_NUM; i++)
            begin
              if (wa == `OFF_CH_BASE + 8'(i) * `CH_STRIDE + `OFF_CH_CTRL)
              begin
                state_next.ch[i].en = wb[`CTRL_EN_BIT];
                state_next.ch[i].oe = wb[`CTRL_OE_BIT];
                state_next.ch[i].pol = wb[`CTRL_POL_BIT];
              end
              else if (wa == `OFF_CH_BASE + 8'(i) * `CH_STRIDE + `OFF_CH_DUTY_HIGH)
                duty_next[i][9:2] = wb;
              else if (wa == `OFF_CH_BASE + 8'(i) * `CH_STRIDE + `OFF_CH_DUTY_LOW)
                duty_next[i][1:0] = wb[7:`DCL_LSB_POS];
            end
          end
          else
            state_next.bresp = 2'h2;
        end
      end
      BUS_BRESP:
      begin
        if (axil_req.bready)
          state_next.wst = BUS_IDLE;
      end
      default: state_next.wst = BUS_IDLE;
    endcase
    case (state_reg.rst)
      BUS_IDLE:
      begin
        if (axil_req.arvalid)
        begin
          state_next.rst = BUS_RRESP;
          state_next.rresp = 2'h0;
          state_next.rdata = 32'h0000_0000;
          if (ra == `OFF_TIMER_CTRL)
            state_next.rdata[7:0] = {5'h00, state_reg.timer_run, state_reg.prescale};
          else if (ra == `OFF_PERIOD)
            state_next.rdata[7:0] = state_reg.period;
          else if (ra == `OFF_TIMER)
            state_next.rdata[7:0] = state_reg.timer;
          else if (ra == `OFF_STATUS)
            state_next.rdata[7:0] = {7'h00, state_reg.match_flag};
          else if (ra >= `OFF_CH_BASE && ra < `OFF_CH_BASE + `CH_NUM * `CH_STRIDE)
          begin
            for (int i = 0; i < `CH_NUM; i++)
            begin
              if (ra == `OFF_CH_BASE + 8'(i) * `CH_STRIDE + `OFF_CH_CTRL)
                state_next.rdata[7:0] = {state_reg.ch[i].en, state_reg.ch[i].oe,
                  pwm_out[i], state_reg.ch[i].pol, 4'h0};
              else if (ra == `OFF_CH_BASE + 8'(i) * `CH_STRIDE + `OFF_CH_DUTY_HIGH)
                state_next.rdata[7:0] = duty_reg[i][9:2];
              else if (ra == `OFF_CH_BASE + 8'(i) * `CH_STRIDE + `OFF_CH_DUTY_LOW)
                state_next.rdata[7:0] = {duty_reg[i][1:0], 6'h00};
            end
          end
          else
            state_next.rresp = 2'h2;
        end
      end
      BUS_RRESP:
      begin
        if (axil_req.rready)
          state_next.rst = BUS_IDLE;
      end
      default: state_next.rst = BUS_IDLE;
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < `CH_NUM; g++)
    begin : gen_ch
      assign pwm_out[g] = state_reg.ch[g].en & (state_reg.ch[g].raw ^ state_reg.ch[g].pol);
      assign pin_out[g] = pin_out_reg[g];
      assign pin_oe[g] = state_reg.ch[g].en & state_reg.ch[g].oe;
      always_ff @(posedge mclk)
      begin
        if (!resetn)
          pin_out_reg[g] <= 1'b0;
        else if (run)
          pin_out_reg[g] <= pwm_out[g];
      end
    end
  endgenerate

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      state_reg <= '0;
      state_reg.wst <= BUS_IDLE;
      state_reg.rst <= BUS_IDLE;
      state_reg.period <= `PERIOD_RESET;
    end
    else if (run)
      state_reg <= state_next;
  end

  // Duty registers have no reset so their contents survive every reset.
  always_ff @(posedge mclk)
  begin
    if (run)
      duty_reg <= duty_next;
  end
endmodule
`default_nettype wire

/* File: core/pwm_regs.svh */
// Register offsets, field positions, reset values and timing constants of the PWM block.
// Included by the package and the design; definitions only.
`ifndef PWM_REGS_SVH
`define PWM_REGS_SVH
`define CH_NUM 4
`define OFF_TIMER_CTRL 8'h00
`define OFF_PERIOD 8'h04
`define OFF_TIMER 8'h08
`define OFF_STATUS 8'h0C
`define OFF_CH_BASE 8'h10
`define CH_STRIDE 8'h10
`define OFF_CH_CTRL 8'h00
`define OFF_CH_DUTY_HIGH 8'h04
`define OFF_CH_DUTY_LOW 8'h08
`define CTRL_EN_BIT 7
`define CTRL_OE_BIT 6
`define CTRL_OUT_BIT 5
`define CTRL_POL_BIT 4
`define TCTRL_RUN_BIT 2
`define DCL_LSB_POS 6
`define CTRL_RESET 8'h00
`define PERIOD_RESET 8'hFF
`define PRESCALE_1 2'h0
`define PRESCALE_4 2'h1
`define PRESCALE_64 2'h2
`define DIV1_TOP 2'h3
`define DIV4_TOP 4'hF
`define DIV64_TOP 8'hFF
`endif

/* File: core/pwm_pkg.sv */
// Types shared by the PWM block: AXI4-Lite bundles and the block's state record.
// Assumes the constants header is on the include path.
`default_nettype none
`include "pwm_regs.svh"
package pwm_pkg;
  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } axil_req_s;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_s;
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_BRESP = 3'b010,
    BUS_RRESP = 3'b100
  } bus_state_e;
  typedef struct packed {
    logic en;
    logic oe;
    logic pol;
    logic [7:0] dch;
    logic [1:0] dcl;
    logic [9:0] duty_buf;
    logic raw;
  } chan_s;
  typedef struct packed {
    bus_state_e wst;
    bus_state_e rst;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic timer_run;
    logic [1:0] prescale;
    logic [7:0] period;
    logic [7:0] timer;
    logic [7:0] pre_cnt;
    logic match_flag;
    chan_s [`CH_NUM-1:0] ch;
  } state_s;
endpackage
`default_nettype wire

/* File: testbench/pwm_monitor.sv */
// Port checker of the PWM block, bound to every instance of it.
// Assumes one clock domain and the package compiled beforehand.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_regs.svh"
module pwm_monitor
  import pwm_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic sleep,
  input wire axil_req_s axil_req,
  input wire axil_rsp_s axil_rsp,
  input wire logic [`CH_NUM-1:0] pwm_out,
  input wire logic [`CH_NUM-1:0] pin_out,
  input wire logic [`CH_NUM-1:0] pin_oe
);
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  wire logic go = clk_en && !sleep;
  AST_PIN_COPY: assert property (go |=> pin_out == $past(pwm_out))
    else $error("pin drive is not last cycle's waveform");
  AST_SLEEP_HOLD: assert property (sleep |=> $stable(pin_out) && $stable(pin_oe))
    else $error("pin moved while asleep");
  AST_SLEEP_BUS: assert property (sleep |=> $stable(pwm_out) && $stable(axil_rsp.bvalid))
    else $error("state moved while asleep");
  AST_FREEZE: assert property (!clk_en |=> $stable(pin_out) && $stable(axil_rsp.rvalid))
    else $error("state moved without clock enable");
  AST_RESET_IDLE: assert property ($rose(resetn) |-> pin_oe == 0 && pin_out == 0)
    else $error("pins not released by reset");
  AST_OE_CAUSE: assert property ($rose(|pin_oe) |-> $past(axil_req.awvalid && axil_rsp.awready))
    else $error("pin enabled without a register write");
  AST_B_ANSWER: assert property (go && axil_req.awvalid && axil_rsp.awready |=> axil_rsp.bvalid)
    else $error("write response late");
  AST_R_STANDS: assert property (axil_rsp.rvalid && !axil_req.rready |=>
    axil_rsp.rvalid && $stable(axil_rsp.rdata))
    else $error("read answer dropped");
  AST_W_PAIR: assert property (axil_rsp.awready |-> axil_rsp.wready && axil_req.wvalid)
    else $error("address taken without data");
  cover property (sleep [*3]);
  cover property ($rose(|pin_oe));
  cover property ($fell(pin_out[0]) && pin_oe[0]);
endmodule
bind shared_period_pwm_channels pwm_monitor i_mon (.mclk(mclk), .resetn(resetn),
  .clk_en(clk_en), .sleep(sleep), .axil_req(axil_req), .axil_rsp(axil_rsp),
  .pwm_out(pwm_out), .pin_out(pin_out), .pin_oe(pin_oe));
`default_nettype wire

/* File: testbench/pin_load_model.sv */
// Pads of the four channel pins as an external load sees them.
// Assumes pin_out and pin_oe of the block; the pads have no pull resistor.
`timescale 1ns/1ps
`default_nettype none
module pin_load_model (
  input wire logic mclk,
  input wire logic [3:0] drv,
  input wire logic [3:0] oe,
  output logic [3:0] pad
);
  logic [3:0] last_reg = 4'h0;
  always_ff @(posedge mclk)
  begin
    last_reg <= pad;
  end
  // A released pad floats, so it toggles rather than keep a stale level.
  assign pad = (oe & drv) | (~oe & ~last_reg);
endmodule
`default_nettype wire

/* File: testbench/shared_period_pwm_channels_test.sv */
// Self-checking bench of the PWM block driving the pad load model.
// Assumes package, design, checker and load model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_regs.svh"
module shared_period_pwm_channels_test
  import pwm_pkg::*;
;
  logic mclk, resetn, clk_en, sleep;
  axil_req_s req;
  axil_rsp_s rsp;
  logic [3:0] pwm, pout, poe, pad;
  logic [31:0] d;
  logic [1:0] r;
  int miscompares, comparisons;
  int dv[4];
  shared_period_pwm_channels i_dut (.mclk(mclk), .resetn(resetn), .clk_en(clk_en),
    .sleep(sleep), .axil_req(req), .axil_rsp(rsp), .pwm_out(pwm), .pin_out(pout),
    .pin_oe(poe));
  pin_load_model i_load (.mclk(mclk), .drv(pout), .oe(poe), .pad(pad));
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  function automatic logic [7:0] ca(int n, logic [7:0] o);
    return `OFF_CH_BASE + 8'(n) * `CH_STRIDE + o;
  endfunction
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] v);
    req.awaddr <= a;
    req.wdata <= v;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    do @(posedge mclk); while (rsp.awready !== 1'b1);
    req.awvalid <= 1'b0;
    req.wvalid <= 1'b0;
    req.bready <= 1'b1;
    do @(posedge mclk); while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    do @(posedge mclk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    req.rready <= 1'b1;
    do @(posedge mclk); while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask
  task automatic duty(int n, int v);
    wr(ca(n, `OFF_CH_DUTY_HIGH), 32'(v >> 2));
    wr(ca(n, `OFF_CH_DUTY_LOW), 32'((v & 3) << 6));
  endtask
  // Period register is 3, so one period is 16 time base steps.
  task automatic meas(logic [1:0] pre, int mult, logic pol);
    int n[4] = '{0, 0, 0, 0};
    int h;
    wr(`OFF_TIMER_CTRL, {29'h0, 1'b1, pre});
    foreach (dv[c]) wr(ca(c, `OFF_CH_CTRL), {24'h0, 3'h6, pol, 4'h0});
    repeat (32 * mult) @(posedge mclk);
    repeat (32 * mult)
    begin
      @(posedge mclk);
      foreach (n[c]) n[c] += int'(pad[c] === 1'b1);
    end
    foreach (n[c])
    begin
      h = (dv[c] >= 12) ? 16 : dv[c];
      h = pol ? 16 - h : h;
      check("high_cycles", n[c], 2 * h * mult);
    end
    check("pin_oe", poe, 4'hF);
  endtask
  task automatic t_regs();
    rd(ca(0, `OFF_CH_CTRL));
    check("ctrl_reset", d, 0);
    wr(ca(1, `OFF_CH_CTRL), 32'h7F);
    rd(ca(1, `OFF_CH_CTRL));
    check("ctrl_bits", d, 32'h50);
    check("pin_oe_off", poe, 4'h0);
    wr(ca(1, `OFF_CH_DUTY_HIGH), 32'hA5);
    wr(ca(1, `OFF_CH_DUTY_LOW), 32'hFF);
    rd(ca(1, `OFF_CH_DUTY_HIGH));
    check("duty_high", d, 32'hA5);
    rd(ca(1, `OFF_CH_DUTY_LOW));
    check("duty_low", d, 32'hC0);
    rd(8'hFC);
    check("unmapped", r, 2'h2);
    $display("registers done");
  endtask
  task automatic t_setup();
    foreach (dv[c])
    begin
      wr(ca(c, `OFF_CH_CTRL), 32'h0);
      dv[c] = 2 + 3 * c;
    end
    wr(`OFF_PERIOD, 32'h3);
    foreach (dv[c]) duty(c, 0);
    wr(`OFF_STATUS, 32'h1);
    wr(`OFF_TIMER_CTRL, 32'h4);
    do rd(`OFF_STATUS); while (d[0] !== 1'b1);
    foreach (dv[c]) duty(c, dv[c]);
    meas(2'h0, 1, 1'b0);
    meas(2'h0, 1, 1'b1);
    $display("duty and polarity done");
  endtask
  task automatic t_prescale();
    meas(2'h1, 4, 1'b0);
    meas(2'h2, 64, 1'b0);
    $display("prescaler done");
  endtask
  task automatic t_limits();
    int h;
    dv[0] = 1023;
    dv[1] = 0;
    duty(0, dv[0]);
    duty(1, dv[1]);
    meas(2'h0, 1, 1'b0);
    wr(ca(3, `OFF_CH_CTRL), 32'h80);
    check("pin_oe_internal", poe, 4'h7);
    h = 0;
    repeat (32)
    begin
      @(posedge mclk);
      h += int'(pwm[3] === 1'b1);
    end
    check("internal_high", h, 2 * dv[3]);
    wr(ca(3, `OFF_CH_CTRL), 32'hC0);
    $display("full and zero duty done");
  endtask
  task automatic t_hold();
    logic [3:0] p, w;
    logic chg;
    for (int k = 0; k < 2; k++)
    begin
      chg = 1'b0;
      if (k == 0)
        sleep <= 1'b1;
      else
        clk_en <= 1'b0;
      @(posedge mclk);
      #1 p = pad;
      w = pwm;
      repeat (30)
      begin
        @(posedge mclk);
        #1 chg = chg | (pad !== p) | (pwm !== w);
      end
      check("held", chg, 0);
      @(posedge mclk);
      sleep <= 1'b0;
      clk_en <= 1'b1;
      @(posedge mclk);
    end
    $display("sleep done");
  endtask
  task automatic t_reset();
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 check("oe_reset", {pout, poe}, 8'h0);
    @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    rd(ca(2, `OFF_CH_CTRL));
    check("ctrl_cleared", d, 0);
    rd(ca(2, `OFF_CH_DUTY_HIGH));
    check("duty_kept", d, 32'(dv[2] >> 2));
    $display("reset done");
  endtask
  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    req = '0;
    clk_en = 1'b1;
    sleep = 1'b0;
    resetn = 1'b0;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_setup();
    t_prescale();
    t_limits();
    t_hold();
    t_reset();
    summarize();
  end
  initial
  begin
    repeat (30000) @(posedge mclk);
    miscompares++;
    summarize();
  end
endmodule
`default_nettype wire
